// ### hw/aac_pkg.sv
/*
  Constants for the amplifier control register bank: function prefixes,
  register reset values, field positions and the serial address layout.
  Assumes nothing beyond being compiled before the design modules.
*/
package aac_pkg;

  // Function prefix in the top three bits of each data byte
  localparam logic [2:0] AAC_FN_INPUT_VOL = 3'h0;
  localparam logic [2:0] AAC_FN_BASS = 3'h1;
  localparam logic [2:0] AAC_FN_TREBLE = 3'h2;
  localparam logic [2:0] AAC_FN_RIGHT_VOL = 3'h3;
  localparam logic [2:0] AAC_FN_LEFT_VOL = 3'h4;
  localparam logic [2:0] AAC_FN_MIC_SEL = 3'h5;
  localparam logic [2:0] AAC_FN_MIC_VOL = 3'h6;
  localparam logic [2:0] AAC_FN_GENERAL = 3'h7;

  // Data byte layout
  localparam int AAC_FN_MSB = 7;
  localparam int AAC_FN_LSB = 5;

  // Reset values and the top tone code
  localparam logic [4:0] AAC_OUT_VOL_MUTE = 5'h1F;
  localparam logic [4:0] AAC_MIC_VOL_MUTE = 5'h15;
  localparam logic [4:0] AAC_GENERAL_RST = 5'h00;
  localparam logic [3:0] AAC_MIC_SEL_RST = 4'h8;
  localparam logic [3:0] AAC_TONE_FLAT = 4'h6;
  localparam logic [3:0] AAC_TONE_MAX = 4'hC;
  localparam logic [2:0] AAC_INPUT_VOL_RST = 3'h0;

  // Microphone selection field layout and the one undefined gain code
  localparam int AAC_MIC_SRC_LSB = 0;
  localparam int AAC_MIC_GAIN_LSB = 2;
  localparam logic [1:0] AAC_MIC_GAIN_BAD = 2'h3;

  // General control bit positions
  localparam int AAC_GC_SHUTDOWN = 0;
  localparam int AAC_GC_GPO = 1;
  localparam int AAC_GC_ENHANCE = 2;
  localparam int AAC_GC_MONO = 3;
  localparam int AAC_GC_EXT_LOOP = 4;

  // Slave address: fixed upper bits, two strap bits, write bit
  localparam logic [4:0] AAC_ADDR_HI = 5'h10;
  localparam logic AAC_ADDR_WRITE = 1'h0;
  localparam logic [3:0] AAC_BITS_PER_BYTE = 4'h8;

  // Number of synchronised pins: scl, sda, two straps, hard reset, bypass settled
  localparam int AAC_NUM_PINS = 6;

endpackage

// ### hw/aac_regs.sv
/*
  Control register bank of a stereo amplifier with microphone preamp,
  written over a two-wire serial link. Holds volume, tone, microphone and
  general control settings and sequences the turn-on buffer mode.
  Assumes the pins arrive asynchronously, the link clock far slower than clk,
  and an analog side that reports when the bypass node has settled.

*/
`timescale 1ns/100ps
module aac_regs
  import aac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link pins
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address straps and hard reset pin
  input wire logic [1:0] addr_strap_pin,
  input wire logic hard_reset_pin,
  // Analog side status
  input wire logic bypass_settled_pin,
  // Output, tone and input settings
  output logic [4:0] left_vol,
  output logic [4:0] right_vol,
  output logic [3:0] bass,
  output logic [3:0] treble,
  output logic [2:0] input_vol,
  // Microphone settings
  output logic [1:0] mic_src,
  output logic [1:0] mic_gain,
  output logic [4:0] mic_vol,
  // General control
  output logic shutdown,
  output logic gpo,
  output logic enhance_on,
  output logic mono_force,
  output logic ext_loop,
  // Turn-on sequencing
  output logic buffer_mode
);

  typedef enum logic [1:0] {
    AAC_P_OFF = 2'h0,
    AAC_P_CHARGE = 2'h1,
    AAC_P_RUN = 2'h2
  } aac_power_state_t;

  // Accepts a write only where the payload is a defined code
  function automatic logic aac_code_ok(input logic [2:0] fn, input logic [4:0] payload);
    logic ok;
    ok = 1'h1;
    case (fn)
      AAC_FN_BASS, AAC_FN_TREBLE: ok = (payload[3:0] <= AAC_TONE_MAX);
      AAC_FN_MIC_SEL: ok = (payload[AAC_MIC_GAIN_LSB +: 2] != AAC_MIC_GAIN_BAD);
      AAC_FN_MIC_VOL: ok = (payload <= AAC_MIC_VOL_MUTE);
      default: ok = 1'h1;
    endcase
    return ok;
  endfunction

  // Two-stage synchronisers for every pin
  logic [AAC_NUM_PINS-1:0] pin_meta;
  logic [AAC_NUM_PINS-1:0] pin_sync;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= 6'h03;
      pin_sync <= 6'h03;
    end else begin
      pin_meta <= {bypass_settled_pin, hard_reset_pin, addr_strap_pin, sda_in, scl_pin};
      pin_sync <= pin_meta;
    end
  end

  wire scl_s = pin_sync[0];
  wire sda_s = pin_sync[1];
  wire [1:0] strap_s = pin_sync[3:2];
  wire hard_reset_s = pin_sync[4];
  wire settled_s = pin_sync[5];

  // Hard reset pin also restarts the link and the power sequence
  wire reg_reset = rst | hard_reset_s;

  wire byte_valid;
  wire [7:0] byte_data;
  wire slave_oe_n;

  aac_serial_slave u_slave (
    .clk(clk),
    .rst(reg_reset),
    .scl(scl_s),
    .sda(sda_s),
    .addr_strap(strap_s),
    .sda_oe_n(slave_oe_n),
    .byte_valid(byte_valid),
    .byte_data(byte_data)
  );

  // Byte decode
  wire [2:0] fn = byte_data[AAC_FN_MSB:AAC_FN_LSB];
  wire [4:0] payload = byte_data[4:0];
  wire write_ok = byte_valid && aac_code_ok(fn, payload);
  wire wr_input = write_ok && (fn == AAC_FN_INPUT_VOL);
  wire wr_bass = write_ok && (fn == AAC_FN_BASS);
  wire wr_treble = write_ok && (fn == AAC_FN_TREBLE);
  wire wr_right = write_ok && (fn == AAC_FN_RIGHT_VOL);
  wire wr_left = write_ok && (fn == AAC_FN_LEFT_VOL);
  wire wr_mic_sel = write_ok && (fn == AAC_FN_MIC_SEL);
  wire wr_mic_vol = write_ok && (fn == AAC_FN_MIC_VOL);
  wire wr_general = write_ok && (fn == AAC_FN_GENERAL);

  // Data wire is only ever pulled low
  always_ff @(posedge clk) begin
    sda_out <= 1'h0;
    sda_oe_n <= reg_reset ? 1'h1 : slave_oe_n;
  end

  // Volume and tone registers
  always_ff @(posedge clk) begin
    if (reg_reset) begin
      left_vol <= AAC_OUT_VOL_MUTE;
      right_vol <= AAC_OUT_VOL_MUTE;
      mic_vol <= AAC_MIC_VOL_MUTE;
      bass <= AAC_TONE_FLAT;
      treble <= AAC_TONE_FLAT;
      input_vol <= AAC_INPUT_VOL_RST;
    end else begin
      // Five-bit codes; all ones mutes left and right, 5'h15 is the microphone mute and top code
      if (wr_left) begin
        left_vol <= payload;
      end
      if (wr_right) begin
        right_vol <= payload;
      end
      if (wr_mic_vol) begin
        mic_vol <= payload;
      end
      // Bit 4 of tone bytes and bits 4:3 of input volume are don't care
      if (wr_bass) begin
        bass <= payload[3:0];
      end
      if (wr_treble) begin
        treble <= payload[3:0];
      end
      if (wr_input) begin
        input_vol <= payload[2:0];
      end
    end
  end

  // Microphone selection; bit 4 is don't care
  always_ff @(posedge clk) begin
    if (reg_reset) begin
      mic_src <= AAC_MIC_SEL_RST[AAC_MIC_SRC_LSB +: 2];
      mic_gain <= AAC_MIC_SEL_RST[AAC_MIC_GAIN_LSB +: 2];
    end else if (wr_mic_sel) begin
      mic_src <= payload[AAC_MIC_SRC_LSB +: 2];
      mic_gain <= payload[AAC_MIC_GAIN_LSB +: 2];
    end
  end

  // General control
  always_ff @(posedge clk) begin
    if (reg_reset) begin
      shutdown <= AAC_GENERAL_RST[AAC_GC_SHUTDOWN];
      gpo <= AAC_GENERAL_RST[AAC_GC_GPO];
      enhance_on <= AAC_GENERAL_RST[AAC_GC_ENHANCE];
      mono_force <= AAC_GENERAL_RST[AAC_GC_MONO];
      ext_loop <= AAC_GENERAL_RST[AAC_GC_EXT_LOOP];
    end else if (wr_general) begin
      shutdown <= payload[AAC_GC_SHUTDOWN];
      gpo <= payload[AAC_GC_GPO];
      enhance_on <= payload[AAC_GC_ENHANCE];
      mono_force <= payload[AAC_GC_MONO];
      ext_loop <= payload[AAC_GC_EXT_LOOP];
    end
  end

  // Turn-on sequencing: buffers until the bypass node reaches half supply
  aac_power_state_t power_state;
  aac_power_state_t next_power_state;

  always_comb begin
    next_power_state = power_state;
    case (power_state)
      AAC_P_OFF: begin
        if (!shutdown) begin
          next_power_state = AAC_P_CHARGE;
        end
      end
      AAC_P_CHARGE: begin
        if (shutdown) begin
          next_power_state = AAC_P_OFF;
        end else if (settled_s) begin
          next_power_state = AAC_P_RUN;
        end
      end
      AAC_P_RUN: begin
        if (shutdown) begin
          next_power_state = AAC_P_OFF;
        end
      end
      default: next_power_state = AAC_P_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reg_reset) begin
      power_state <= AAC_P_CHARGE;
      buffer_mode <= 1'h1;
    end else begin
      power_state <= next_power_state;
      buffer_mode <= (next_power_state != AAC_P_RUN);
    end
  end

endmodule

// ### hw/aac_serial_slave.sv
/*
  Write-only serial slave: finds start and stop, matches the chip address,
  acknowledges the address and every data byte, and hands each data byte on.
  Assumes scl and sda already synchronised to clk, sampled well above the
  link rate, and an external pull-up on the data wire.
*/
`timescale 1ns/100ps
module aac_serial_slave
  import aac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Synchronised link and strap levels
  input wire logic scl,
  input wire logic sda,
  input wire logic [1:0] addr_strap,
  // Open-drain data drive, low while pulling the wire low
  output logic sda_oe_n,
  // Received data byte
  output logic byte_valid,
  output logic [7:0] byte_data
);

  typedef enum logic [2:0] {
    AAC_S_IDLE = 3'h0,
    AAC_S_ADDR = 3'h1,
    AAC_S_ADDR_ACK = 3'h2,
    AAC_S_DATA = 3'h3,
    AAC_S_DATA_ACK = 3'h4
  } aac_slave_state_t;

  aac_slave_state_t state;
  logic scl_prev;
  logic sda_prev;
  logic [7:0] shift;
  logic [3:0] bit_count;

  wire scl_rise = scl & ~scl_prev;
  wire scl_fall = ~scl & scl_prev;
  wire start_seen = scl & scl_prev & sda_prev & ~sda;
  wire stop_seen = scl & scl_prev & ~sda_prev & sda;
  wire byte_done = (bit_count == AAC_BITS_PER_BYTE);
  wire shifting = (state == AAC_S_ADDR) || (state == AAC_S_DATA);
  // Strap bits fill the two address positions above the write bit
  wire addr_match = (shift == {AAC_ADDR_HI, addr_strap, AAC_ADDR_WRITE});

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_prev <= 1'h1;
      sda_prev <= 1'h1;
    end else begin
      scl_prev <= scl;
      sda_prev <= sda;
    end
  end

  always_ff @(posedge clk) begin
    byte_valid <= 1'h0;
    if (rst) begin
      state <= AAC_S_IDLE;
      sda_oe_n <= 1'h1;
      shift <= 8'h00;
      bit_count <= 4'h0;
      byte_data <= 8'h00;
    end else if (start_seen) begin
      // Repeated start is legal anywhere
      state <= AAC_S_ADDR;
      sda_oe_n <= 1'h1;
      bit_count <= 4'h0;
    end else if (stop_seen) begin
      state <= AAC_S_IDLE;
      sda_oe_n <= 1'h1;
    end else if (scl_rise && shifting && !byte_done) begin
      shift <= {shift[6:0], sda};
      bit_count <= bit_count + 4'h1;
    end else if (scl_fall) begin
      case (state)
        AAC_S_ADDR: begin
          if (byte_done) begin
            // Reads and foreign addresses are left unanswered
            state <= addr_match ? AAC_S_ADDR_ACK : AAC_S_IDLE;
            sda_oe_n <= ~addr_match;
          end
        end
        AAC_S_DATA: begin
          if (byte_done) begin
            state <= AAC_S_DATA_ACK;
            sda_oe_n <= 1'h0;
            byte_valid <= 1'h1;
            byte_data <= shift;
          end
        end
        AAC_S_ADDR_ACK, AAC_S_DATA_ACK: begin
          // Further bytes may follow until stop
          state <= AAC_S_DATA;
          sda_oe_n <= 1'h1;
          bit_count <= 4'h0;
        end
        default: begin
          state <= AAC_S_IDLE;
          sda_oe_n <= 1'h1;
        end
      endcase
    end
  end

endmodule

// ### sim/aac_link_master.sv
/*
  Link master model: drives clock and data, reports each acknowledge.
  Assumes the bench resolves the pulled-up data wire.
*/
`timescale 1ns/100ps
module aac_link_master (
  // Link wires
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line,
  // byte_done toggles once a byte; ack_seen holds the last acknowledge level
  output logic byte_done,
  output logic ack_seen
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    byte_done = 1'b0;
    ack_seen = 1'b0;
  end
  // Clock rests high between frames
  task automatic start_frame();
    #103 sda_drv = 1'b0;
    #100 scl = 1'b0;
  endtask
  task automatic clock_bit(input logic b);
    #50 sda_drv = b;
    #50 scl = 1'b1;
    #100 scl = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) clock_bit(b[i]);
    #50 sda_drv = 1'b1;
    #50 scl = 1'b1;
    #50 ack_seen = ~sda_line;
    #50 scl = 1'b0;
    byte_done = ~byte_done;
  endtask
  task automatic stop_frame();
    #50 sda_drv = 1'b0;
    #50 scl = 1'b1;
    #50 sda_drv = 1'b1;
    #100;
  endtask
endmodule

// ### sim/aac_regs_bench.sv
/*
  Bench for the amplifier control register bank.
  Assumes design, checker and link master compiled first.
*/
`timescale 1ns/100ps
module aac_regs_bench;
  import aac_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic hard_reset_pin = 0;
  logic bypass_settled_pin = 0;
  logic [1:0] addr_strap_pin = 2'h0;
  logic scl, sda_drv, done_tgl, ack_seen, sda_out, sda_oe_n;
  logic [4:0] left_vol, right_vol, mic_vol, e_l, e_r, e_mv, e_gen;
  logic [3:0] bass, treble, e_bass, e_treb;
  logic [2:0] input_vol, e_in;
  logic [1:0] mic_src, mic_gain, e_src, e_gain;
  logic shutdown, gpo, enhance_on, mono_force, ext_loop, buffer_mode;
  logic [36:0] notes[$];
  logic [7:0] bq[$];
  logic [31:0] rs = 32'h0000_43fc;
  logic [31:0] r;
  int err_count = 0;
  int n_compared = 0;
  // Pulled up unless the master or the device drives low
  wire sda_line = sda_drv & (sda_oe_n | sda_out);
  always #12.5 clk = ~clk;
  aac_regs DUT (.clk, .rst, .scl_pin(scl), .sda_in(sda_line), .sda_out, .sda_oe_n, .addr_strap_pin,
    .hard_reset_pin, .bypass_settled_pin, .left_vol, .right_vol, .bass, .treble, .input_vol, .mic_src,
    .mic_gain, .mic_vol, .shutdown, .gpo, .enhance_on, .mono_force, .ext_loop, .buffer_mode);
  aac_link_master u_master (.scl, .sda_drv, .sda_line, .byte_done(done_tgl), .ack_seen);
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [36:0] expect_now(input logic ack);
    return {ack, e_gen[0] | ~bypass_settled_pin, e_l, e_r, e_bass, e_treb, e_in, e_src, e_gain, e_mv, e_gen};
  endfunction
  function automatic logic [36:0] seen_now();
    return {ack_seen, buffer_mode, left_vol, right_vol, bass, treble, input_vol, mic_src, mic_gain, mic_vol,
      ext_loop, mono_force, enhance_on, gpo, shutdown};
  endfunction
  task automatic load_defaults();
    {e_l, e_r, e_mv, e_gen} = {AAC_OUT_VOL_MUTE, AAC_OUT_VOL_MUTE, AAC_MIC_VOL_MUTE, AAC_GENERAL_RST};
    {e_bass, e_treb, e_in, e_gain, e_src} = {AAC_TONE_FLAT, AAC_TONE_FLAT, AAC_INPUT_VOL_RST, AAC_MIC_SEL_RST};
  endtask
  task automatic apply(input logic [7:0] b);
    case (b[7:5])
      3'h0: e_in = b[2:0];
      3'h1: if (b[3:0] <= 4'hC) e_bass = b[3:0];
      3'h2: if (b[3:0] <= 4'hC) e_treb = b[3:0];
      3'h3: e_r = b[4:0];
      3'h4: e_l = b[4:0];
      3'h5: if (b[3:2] != 2'h3) {e_gain, e_src} = b[3:0];
      3'h6: if (b[4:0] <= 5'h15) e_mv = b[4:0];
      default: e_gen = b[4:0];
    endcase
  endtask
  task automatic check(input string what, input logic [36:0] seen, input logic [36:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic frame(input logic [7:0] a);
    logic hit;
    hit = (a === {AAC_ADDR_HI, addr_strap_pin, AAC_ADDR_WRITE});
    u_master.start_frame();
    notes.push_back(expect_now(hit));
    u_master.send_byte(a);
    foreach (bq[i]) begin
      if (hit) apply(bq[i]);
      notes.push_back(expect_now(hit));
      u_master.send_byte(bq[i]);
    end
    u_master.stop_frame();
    bq.delete();
  endtask
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Each result is the register state seen after an acknowledge slot
  always @(done_tgl) begin
    if (notes.size() > 0) check("byte", seen_now(), notes.pop_front());
  end
  initial begin
    load_defaults();
    repeat (4) @(negedge clk);
    rst = 0;
    repeat (4) @(negedge clk);
    check("power_up", seen_now(), expect_now(1'b0));
    bypass_settled_pin = 1;
    addr_strap_pin = 2'h2;
    repeat (10) @(negedge clk);
    bq = '{8'h85};
    frame(8'h82);
    bq = '{8'h85};
    frame(8'h85);
    bq = '{8'h80, 8'h9E, 8'h9F, 8'h60, 8'h7E, 8'hA0, 8'hA5, 8'hAA, 8'hAF, 8'hB7, 8'hC0, 8'hD4, 8'hD6, 8'hD5,
      8'h2C, 8'h2D, 8'h53, 8'h1F, 8'hE1, 8'hE2, 8'hE4, 8'hE8, 8'hF0, 8'hE0};
    frame(8'h84);
    for (int n = 0; n < 24; n++) begin
      r = rnd();
      @(negedge clk);
      addr_strap_pin = r[1:0];
      bq = '{r[31:24], r[23:16]};
      frame({AAC_ADDR_HI, r[4] ? r[1:0] : r[3:2], AAC_ADDR_WRITE});
    end
    // Leaving shutdown must wait for the bypass node again
    bq = '{8'hE1};
    frame({AAC_ADDR_HI, addr_strap_pin, AAC_ADDR_WRITE});
    @(negedge clk);
    bypass_settled_pin = 0;
    bq = '{8'hE0};
    frame({AAC_ADDR_HI, addr_strap_pin, AAC_ADDR_WRITE});
    @(negedge clk);
    bypass_settled_pin = 1;
    repeat (6) @(negedge clk);
    check("turn_on", seen_now(), expect_now(1'b1));
    for (int k = 0; k < 2; k++) begin
      bq = '{8'h8A, 8'hE1};
      frame({AAC_ADDR_HI, addr_strap_pin, AAC_ADDR_WRITE});
      @(negedge clk);
      if (k == 0) rst = 1;
      else hard_reset_pin = 1;
      repeat (4) @(negedge clk);
      rst = 0;
      hard_reset_pin = 0;
      load_defaults();
      repeat (8) @(negedge clk);
      check("reset", seen_now(), expect_now(1'b1));
    end
    check("leftover", 37'(notes.size()), 37'h0);
    stop_test();
  end
  initial begin
    #(1_000_000);
    err_count++;
    stop_test();
  end
endmodule

// ### sim/aac_regs_monitor.sv
/*
  Checker bound to the amplifier control register bank.
  Assumes two-flop synchronisers on every pin.
*/
`timescale 1ns/100ps
module aac_regs_monitor
  import aac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins
  input wire logic sda_oe_n,
  input wire logic hard_reset_pin,
  input wire logic bypass_settled_pin,
  // Settings
  input wire logic [4:0] left_vol,
  input wire logic [4:0] right_vol,
  input wire logic [4:0] mic_vol,
  input wire logic [3:0] bass,
  input wire logic [3:0] treble,
  input wire logic [1:0] mic_src,
  input wire logic [1:0] mic_gain,
  input wire logic shutdown,
  input wire logic gpo,
  input wire logic enhance_on,
  input wire logic mono_force,
  input wire logic ext_loop,
  input wire logic buffer_mode
);
  default clocking cb @(posedge clk);
  endclocking
  sequence s_ack_begin;
    $fell(sda_oe_n);
  endsequence
  sequence s_ack_held;
    !sda_oe_n [*3];
  endsequence
  sequence s_hard_held;
    hard_reset_pin [*4];
  endsequence
  property p_ack_hold;
    disable iff (rst) s_ack_begin |=> s_ack_held;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack pulse cut short");
  property p_rst_vol;
    rst |=> left_vol == AAC_OUT_VOL_MUTE && right_vol == AAC_OUT_VOL_MUTE && mic_vol == AAC_MIC_VOL_MUTE;
  endproperty
  a_rst_vol: assert property (p_rst_vol) else $error("volume reset value");
  property p_rst_gen;
    rst |=> {ext_loop, mono_force, enhance_on, gpo, shutdown} == AAC_GENERAL_RST && buffer_mode && sda_oe_n;
  endproperty
  a_rst_gen: assert property (p_rst_gen) else $error("general reset value");
  property p_rst_mic;
    rst |=> {mic_gain, mic_src} == AAC_MIC_SEL_RST && bass == AAC_TONE_FLAT && treble == AAC_TONE_FLAT;
  endproperty
  a_rst_mic: assert property (p_rst_mic) else $error("mic or tone reset value");
  property p_hard;
    disable iff (rst) s_hard_held |=> left_vol == AAC_OUT_VOL_MUTE && mic_vol == AAC_MIC_VOL_MUTE && !shutdown;
  endproperty
  a_hard: assert property (p_hard) else $error("hard reset ignored");
  property p_legal;
    disable iff (rst) mic_gain != AAC_MIC_GAIN_BAD && mic_vol <= AAC_MIC_VOL_MUTE && bass <= AAC_TONE_MAX &&
      treble <= AAC_TONE_MAX;
  endproperty
  a_legal: assert property (p_legal) else $error("undefined code stored");
  property p_shut_buf;
    disable iff (rst) shutdown |=> buffer_mode;
  endproperty
  a_shut_buf: assert property (p_shut_buf) else $error("shutdown without buffer mode");
  property p_leave_buf;
    disable iff (rst) $fell(buffer_mode) |-> !shutdown && $past(bypass_settled_pin, 3);
  endproperty
  a_leave_buf: assert property (p_leave_buf) else $error("left buffer mode early");
endmodule
bind aac_regs aac_regs_monitor u_mon (.clk, .rst, .sda_oe_n, .hard_reset_pin, .bypass_settled_pin,
  .left_vol, .right_vol, .mic_vol, .bass, .treble, .mic_src, .mic_gain, .shutdown, .gpo, .enhance_on,
  .mono_force, .ext_loop, .buffer_mode);
